// file: rtl/mcr_pkg.sv
// Behaviour
// - Four router octets, 0..255, reset zero
// - Apply value 1 commits router and port
// - Alarm reads 0 normal, 1 alarmed
// - Writing 0 during alarm clears it; an alarm event in the same cycle wins and keeps it set
// - Value 1 clears all maxima and minima
// - Value 1 clears every energy total
// - Value 1 clears active energy only
// - Value 1 clears regenerative energy only
// - Value 1 clears reactive energy totals
// - Value 1 clears apparent energy only
// - Value 1 loads staged preset into total
package mcr_pkg;
   // Register word addresses on the host register port
   localparam logic [15:0] A_GW1       = 16'h0120;
   localparam logic [15:0] A_GW2       = 16'h0121;
   localparam logic [15:0] A_GW3       = 16'h0122;
   localparam logic [15:0] A_GW4       = 16'h0123;
   localparam logic [15:0] A_PORT      = 16'h0124;
   localparam logic [15:0] A_NET_APPLY = 16'h0125;
   localparam logic [15:0] A_INTEG     = 16'h012c;
   localparam logic [15:0] A_OPT_INTEG = 16'h012d;
   localparam logic [15:0] A_DEM_RUN   = 16'h0136;
   localparam logic [15:0] A_DEM_ALM   = 16'h0137;
   localparam logic [15:0] A_EXT_CLR   = 16'h015e;
   localparam logic [15:0] A_E_ALL     = 16'h015f;
   localparam logic [15:0] A_E_ACT     = 16'h0160;
   localparam logic [15:0] A_E_REGEN   = 16'h0161;
   localparam logic [15:0] A_E_REACT   = 16'h0162;
   localparam logic [15:0] A_E_APPAR   = 16'h0163;
   localparam logic [15:0] A_PRE_LO    = 16'h0172;
   localparam logic [15:0] A_PRE_HI    = 16'h0173;
   localparam logic [15:0] A_PRE_APPLY = 16'h0174;
   localparam logic [15:0] A_RGN_PRE_LO = 16'h0175;
   // Data values
   localparam logic [15:0] CMD_GO      = 16'h0001;
   localparam logic [15:0] ALM_CLR_VAL = 16'h0000;
   localparam logic [15:0] OCTET_MAX   = 16'h00ff;
   localparam logic [15:0] PORT_FIXED  = 16'h01f6;
   localparam logic [15:0] PORT_MIN    = 16'h0400;
   localparam logic [15:0] PORT_RST    = 16'h01f6;
   localparam logic [7:0]  GW_RST      = 8'h00;
   localparam logic        INTEG_RST   = 1'b1;
   localparam logic        OPT_RST     = 1'b0;
   localparam logic        DEM_RST     = 1'b0;
   localparam logic        ALM_RST     = 1'b0;
   // Command pulse positions
   localparam int C_EXT   = 0;
   localparam int C_ACT   = 1;
   localparam int C_REGEN = 2;
   localparam int C_REACT = 3;
   localparam int C_APPAR = 4;
   localparam int C_PRE   = 5;
   localparam int C_NET   = 6;
   localparam int NCMD    = 7;

   // Listen port legal: fixed value or upper range
   function automatic logic port_ok(input logic [15:0] p);
      port_ok = (p == PORT_FIXED) || (p >= PORT_MIN);
   endfunction

   // Run-control write value legal: 0 or 1 only
   function automatic logic bit_ok(input logic [15:0] d);
      bit_ok = (d[15:1] == 15'h0000);
   endfunction
endpackage

// file: rtl/mcr_cmd_pulse.sv
`timescale 1ns/1ns
// Turns command-register hits into one-cycle pulses
module mcr_cmd_pulse #(
   parameter int N = 7
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [N-1:0] hit,
   input  wire logic [15:0]  wdata,
   output logic      [N-1:0] pulse_reg
);
   logic [N-1:0] pulse_next;   // Pulse next value

   initial begin
      if (N < 1) begin
         $error("mcr_cmd_pulse: N must be at least 1");
      end
   end

   // Only the value 1 fires; any other value is dropped
   always_comb begin
      pulse_next = hit & {N{wdata == mcr_pkg::CMD_GO}};
   end

   // Pulse register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulse_reg <= '0;
      end else begin
         pulse_reg <= pulse_next;
      end
   end

   // A pulse needs a hit with value 1 one cycle earlier
   AST_CMD_CAUSE: assert property (@(posedge clk) disable iff (reset)
      (pulse_reg != '0) |-> $past(wdata) == mcr_pkg::CMD_GO && $past(hit) == pulse_reg)
      else $error("command pulse without a write of 1");
endmodule // mcr_cmd_pulse

// file: rtl/mcr_net_commit.sv
`timescale 1ns/1ns
// Holds the network settings in effect; loads staged ones on apply
module mcr_net_commit (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        apply,
   input  wire logic [7:0]  stg_gw1,
   input  wire logic [7:0]  stg_gw2,
   input  wire logic [7:0]  stg_gw3,
   input  wire logic [7:0]  stg_gw4,
   input  wire logic [15:0] stg_port,
   output logic      [7:0]  gw1_reg,
   output logic      [7:0]  gw2_reg,
   output logic      [7:0]  gw3_reg,
   output logic      [7:0]  gw4_reg,
   output logic      [15:0] port_reg
);
   logic [7:0]  gw1_next;   // Active octet next values
   logic [7:0]  gw2_next;
   logic [7:0]  gw3_next;
   logic [7:0]  gw4_next;
   logic [15:0] port_next;  // Active port next value

   // Copy staged set only on apply
   always_comb begin
      gw1_next  = apply ? stg_gw1 : gw1_reg;
      gw2_next  = apply ? stg_gw2 : gw2_reg;
      gw3_next  = apply ? stg_gw3 : gw3_reg;
      gw4_next  = apply ? stg_gw4 : gw4_reg;
      port_next = apply ? stg_port : port_reg;
   end

   // Active settings registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gw1_reg  <= mcr_pkg::GW_RST;
         gw2_reg  <= mcr_pkg::GW_RST;
         gw3_reg  <= mcr_pkg::GW_RST;
         gw4_reg  <= mcr_pkg::GW_RST;
         port_reg <= mcr_pkg::PORT_RST;
      end else begin
         gw1_reg  <= gw1_next;
         gw2_reg  <= gw2_next;
         gw3_reg  <= gw3_next;
         gw4_reg  <= gw4_next;
         port_reg <= port_next;
      end
   end

   // Active settings move only after an apply
   AST_NET_HOLD: assert property (@(posedge clk) disable iff (reset)
      !$past(apply) |-> $stable(port_reg) && $stable(gw1_reg) && $stable(gw4_reg))
      else $error("network settings changed without apply");
endmodule // mcr_net_commit

// file: rtl/mcr_reg_bank.sv
`timescale 1ns/1ns
// Meter parameter and control register bank
module mcr_reg_bank (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        host_wr,          // Write request
   input  wire logic        host_rd,          // Read request
   input  wire logic [15:0] host_addr,        // Register word address
   input  wire logic [15:0] host_wdata,       // Write data
   input  wire logic        alarm_event,      // Demand alarm raised
   output logic      [15:0] host_rdata,
   output logic             host_ack,
   output logic      [7:0]  gw_active1,
   output logic      [7:0]  gw_active2,
   output logic      [7:0]  gw_active3,
   output logic      [7:0]  gw_active4,
   output logic      [15:0] port_active,
   output logic             net_applied,
   output logic             integ_run,
   output logic             opt_integ_run,
   output logic             demand_run,
   output logic             demand_alarm,
   output logic             extremes_clear,
   output logic             active_clear,
   output logic             regen_clear,
   output logic             reactive_clear,
   output logic             apparent_clear,
   output logic             preset_load,
   output logic      [31:0] preset_value
);
   // Staged router octets and listen port
   logic [7:0]  gw_reg [4];
   logic [7:0]  gw_next [4];
   logic [15:0] port_reg;
   logic [15:0] port_next;
   // Run controls and alarm
   logic        integ_reg;
   logic        integ_next;
   logic        opt_reg;
   logic        opt_next;
   logic        dem_reg;
   logic        dem_next;
   logic        alarm_reg;
   logic        alarm_next;
   // Preset staging, written only
   logic [15:0] pre_lo_reg;
   logic [15:0] pre_lo_next;
   logic [15:0] pre_hi_reg;
   logic [15:0] pre_hi_next;
   logic [15:0] rgn_lo_reg;
   logic [15:0] rgn_lo_next;
   logic [31:0] pre_val_reg;
   logic [31:0] pre_val_next;
   // Read answer
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        ack_reg;
   logic        ack_next;
   // Command decode
   logic [mcr_pkg::NCMD-1:0] hit;
   logic [mcr_pkg::NCMD-1:0] pulse;
   logic        go;

   // Write strobe for one address
   function automatic logic wr_at(input logic [15:0] a);
      wr_at = host_wr && (host_addr == a);
   endfunction

   // Command hits; all-clear fans out to the four totals
   always_comb begin
      go = (host_wdata == mcr_pkg::CMD_GO);
      hit = '0;
      hit[mcr_pkg::C_EXT]   = wr_at(mcr_pkg::A_EXT_CLR);
      hit[mcr_pkg::C_ACT]   = wr_at(mcr_pkg::A_E_ACT) || wr_at(mcr_pkg::A_E_ALL);
      hit[mcr_pkg::C_REGEN] = wr_at(mcr_pkg::A_E_REGEN) || wr_at(mcr_pkg::A_E_ALL);
      hit[mcr_pkg::C_REACT] = wr_at(mcr_pkg::A_E_REACT) || wr_at(mcr_pkg::A_E_ALL);
      hit[mcr_pkg::C_APPAR] = wr_at(mcr_pkg::A_E_APPAR) || wr_at(mcr_pkg::A_E_ALL);
      hit[mcr_pkg::C_PRE]   = wr_at(mcr_pkg::A_PRE_APPLY);
      hit[mcr_pkg::C_NET]   = wr_at(mcr_pkg::A_NET_APPLY);
   end

   // Command pulse generator
   mcr_cmd_pulse #(
      .N         (mcr_pkg::NCMD)
   ) u_cmd (
      .clk       (clk),
      .reset     (reset),
      .hit       (hit),
      .wdata     (host_wdata),
      .pulse_reg (pulse)
   );

   // Settings in effect, loaded by the apply pulse
   mcr_net_commit u_net (
      .clk      (clk),
      .reset    (reset),
      .apply    (pulse[mcr_pkg::C_NET]),
      .stg_gw1  (gw_reg[0]),
      .stg_gw2  (gw_reg[1]),
      .stg_gw3  (gw_reg[2]),
      .stg_gw4  (gw_reg[3]),
      .stg_port (port_reg),
      .gw1_reg  (gw_active1),
      .gw2_reg  (gw_active2),
      .gw3_reg  (gw_active3),
      .gw4_reg  (gw_active4),
      .port_reg (port_active)
   );

   // Next values of the staged and control registers
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gw_next[i] = gw_reg[i];
      end
      // Octets above 255 are refused
      if (host_wr && host_wdata <= mcr_pkg::OCTET_MAX) begin
         if (host_addr == mcr_pkg::A_GW1) gw_next[0] = host_wdata[7:0];
         if (host_addr == mcr_pkg::A_GW2) gw_next[1] = host_wdata[7:0];
         if (host_addr == mcr_pkg::A_GW3) gw_next[2] = host_wdata[7:0];
         if (host_addr == mcr_pkg::A_GW4) gw_next[3] = host_wdata[7:0];
      end
      // Out-of-range port values are refused
      port_next = port_reg;
      if (wr_at(mcr_pkg::A_PORT) && mcr_pkg::port_ok(host_wdata)) begin
         port_next = host_wdata;
      end
      // Run bits accept only 0 or 1
      integ_next = integ_reg;
      opt_next   = opt_reg;
      dem_next   = dem_reg;
      if (mcr_pkg::bit_ok(host_wdata)) begin
         if (wr_at(mcr_pkg::A_INTEG))     integ_next = host_wdata[0];
         if (wr_at(mcr_pkg::A_OPT_INTEG)) opt_next   = host_wdata[0];
         if (wr_at(mcr_pkg::A_DEM_RUN))   dem_next   = host_wdata[0];
      end
      // Alarm: raise wins over a clearing write
      alarm_next = alarm_reg;
      if (alarm_event) begin
         alarm_next = 1'b1;
      end else if (wr_at(mcr_pkg::A_DEM_ALM) && host_wdata == mcr_pkg::ALM_CLR_VAL) begin
         alarm_next = 1'b0;
      end
      // Preset halves and the regenerative low half
      pre_lo_next = wr_at(mcr_pkg::A_PRE_LO) ? host_wdata : pre_lo_reg;
      pre_hi_next = wr_at(mcr_pkg::A_PRE_HI) ? host_wdata : pre_hi_reg;
      rgn_lo_next = wr_at(mcr_pkg::A_RGN_PRE_LO) ? host_wdata : rgn_lo_reg;
      // Preset value captured with the load pulse
      pre_val_next = pre_val_reg;
      if (hit[mcr_pkg::C_PRE] && go) begin
         pre_val_next = {pre_hi_reg, pre_lo_reg};
      end
   end

   // Read mux; write-only and unmapped words read zero
   always_comb begin
      rdata_next = rdata_reg;
      ack_next   = host_wr || host_rd;
      if (host_rd) begin
         unique case (host_addr)
            mcr_pkg::A_GW1:       rdata_next = {8'h00, gw_reg[0]};
            mcr_pkg::A_GW2:       rdata_next = {8'h00, gw_reg[1]};
            mcr_pkg::A_GW3:       rdata_next = {8'h00, gw_reg[2]};
            mcr_pkg::A_GW4:       rdata_next = {8'h00, gw_reg[3]};
            mcr_pkg::A_PORT:      rdata_next = port_reg;
            mcr_pkg::A_INTEG:     rdata_next = {15'h0000, integ_reg};
            mcr_pkg::A_OPT_INTEG: rdata_next = {15'h0000, opt_reg};
            mcr_pkg::A_DEM_RUN:   rdata_next = {15'h0000, dem_reg};
            mcr_pkg::A_DEM_ALM:   rdata_next = {15'h0000, alarm_reg};
            default:              rdata_next = 16'h0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            gw_reg[i] <= mcr_pkg::GW_RST;
         end
         port_reg    <= mcr_pkg::PORT_RST;
         integ_reg   <= mcr_pkg::INTEG_RST;
         opt_reg     <= mcr_pkg::OPT_RST;
         dem_reg     <= mcr_pkg::DEM_RST;
         alarm_reg   <= mcr_pkg::ALM_RST;
         pre_lo_reg  <= 16'h0000;
         pre_hi_reg  <= 16'h0000;
         rgn_lo_reg  <= 16'h0000;
         pre_val_reg <= 32'h0000_0000;
         rdata_reg   <= 16'h0000;
         ack_reg     <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            gw_reg[i] <= gw_next[i];
         end
         port_reg    <= port_next;
         integ_reg   <= integ_next;
         opt_reg     <= opt_next;
         dem_reg     <= dem_next;
         alarm_reg   <= alarm_next;
         pre_lo_reg  <= pre_lo_next;
         pre_hi_reg  <= pre_hi_next;
         rgn_lo_reg  <= rgn_lo_next;
         pre_val_reg <= pre_val_next;
         rdata_reg   <= rdata_next;
         ack_reg     <= ack_next;
      end
   end

   // Outputs, each straight from a flop
   assign host_rdata     = rdata_reg;
   assign host_ack       = ack_reg;
   assign integ_run      = integ_reg;
   assign opt_integ_run  = opt_reg;
   assign demand_run     = dem_reg;
   assign demand_alarm   = alarm_reg;
   assign net_applied    = pulse[mcr_pkg::C_NET];
   assign extremes_clear = pulse[mcr_pkg::C_EXT];
   assign active_clear   = pulse[mcr_pkg::C_ACT];
   assign regen_clear    = pulse[mcr_pkg::C_REGEN];
   assign reactive_clear = pulse[mcr_pkg::C_REACT];
   assign apparent_clear = pulse[mcr_pkg::C_APPAR];
   assign preset_load    = pulse[mcr_pkg::C_PRE];
   assign preset_value   = pre_val_reg;

   // Octet write of legal value is read back next read
   AST_GW_STORE: assert property (@(posedge clk) disable iff (reset)
      host_wr && host_addr == mcr_pkg::A_GW3 && host_wdata <= mcr_pkg::OCTET_MAX
      |=> gw_reg[2] == $past(host_wdata[7:0]))
      else $error("router octet not stored");

   // Apply of 1 pulses, then staged port and octet take effect
   AST_NET_APPLY: assert property (@(posedge clk) disable iff (reset)
      host_wr && host_addr == mcr_pkg::A_NET_APPLY && host_wdata == mcr_pkg::CMD_GO
      |=> net_applied ##1 (port_active == $past(port_reg) && gw_active1 == $past(gw_reg[0])))
      else $error("network apply not taken");

   // Active port is always a legal value
   AST_PORT_LEGAL: assert property (@(posedge clk) disable iff (reset)
      mcr_pkg::port_ok(port_active) && mcr_pkg::port_ok(port_reg))
      else $error("listen port out of range");

   // Alarm event shows on the alarm flag next cycle
   AST_ALM_SET: assert property (@(posedge clk) disable iff (reset)
      alarm_event |=> demand_alarm)
      else $error("alarm event lost");

   // Writing 0 with no new event clears the alarm
   AST_ALM_CLR: assert property (@(posedge clk) disable iff (reset)
      demand_alarm && !alarm_event && host_wr && host_addr == mcr_pkg::A_DEM_ALM
      && host_wdata == mcr_pkg::ALM_CLR_VAL |=> !demand_alarm)
      else $error("alarm not cleared by write of 0");

   // All-clear of 1 fires all four energy clears together
   AST_ALL_CLR: assert property (@(posedge clk) disable iff (reset)
      host_wr && host_addr == mcr_pkg::A_E_ALL && host_wdata == mcr_pkg::CMD_GO
      |=> active_clear && regen_clear && reactive_clear && apparent_clear)
      else $error("all-energy clear incomplete");

   // Active-only clear leaves other totals alone
   AST_ACT_ONLY: assert property (@(posedge clk) disable iff (reset)
      host_wr && host_addr == mcr_pkg::A_E_ACT
      |=> !regen_clear && !reactive_clear && !apparent_clear)
      else $error("active clear touched another total");

   // Non-1 value to the extremes clear does nothing
   AST_EXT_IGN: assert property (@(posedge clk) disable iff (reset)
      host_wr && host_addr == mcr_pkg::A_EXT_CLR && host_wdata != mcr_pkg::CMD_GO
      |=> !extremes_clear)
      else $error("extremes cleared by a value other than 1");

   // Load pulse carries the staged halves high:low
   AST_PRESET: assert property (@(posedge clk) disable iff (reset)
      preset_load |-> preset_value == {$past(pre_hi_reg), $past(pre_lo_reg)})
      else $error("preset value does not match staged halves");

   // Demand run bit changes only by a write of 0 or 1
   AST_RUN_HOLD: assert property (@(posedge clk) disable iff (reset)
      !(host_wr && host_addr == mcr_pkg::A_DEM_RUN && mcr_pkg::bit_ok(host_wdata))
      |=> $stable(demand_run))
      else $error("demand run changed without a legal write");
endmodule // mcr_reg_bank

// file: tb/mcr_host_model.sv
`timescale 1ns/1ns
// Remote host stand-in: one register request per clock, register port only
module mcr_host_model (
   input  wire logic        clk,
   output logic             host_wr,
   output logic             host_rd,
   output logic      [15:0] host_addr,
   output logic      [15:0] host_wdata
);
   // Quiet bus at time zero
   initial begin
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      host_addr  = 16'h0000;
      host_wdata = 16'h0000;
   end

   // Request is taken on the next rising edge; lines stay up for back-to-back use
   task automatic op(input logic w, input logic r, input logic [15:0] a,
                     input logic [15:0] d);
      host_wr    = w;
      host_rd    = r;
      host_addr  = a;
      host_wdata = d;
      @(posedge clk);
      #1;
   endtask

   // Release: address and data flip so stale values never look valid
   task automatic idle();
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      host_addr  = ~host_addr;
      host_wdata = ~host_wdata;
      @(posedge clk);
      #1;
   endtask

   // 32-bit value staged as low half, then high half one word up
   task automatic stage32(input logic [15:0] lo_addr, input logic [31:0] v);
      op(1'b1, 1'b0, lo_addr, v[15:0]);
      op(1'b1, 1'b0, lo_addr + 16'h0001, v[31:16]);
   endtask
endmodule // mcr_host_model

// file: tb/mcr_reg_bank_bench.sv
`timescale 1ns/1ns
// Bench compare: counts every check, reports a mismatch at once
`define chk(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch at %0t: got %h want %h", $time, (got), (exp)); end end
// Self-checking bench for the meter register bank
module mcr_reg_bank_bench;
   // Expected answer for one request
   typedef struct {
      logic        rd;
      logic [15:0] data;
      logic [6:0]  pulses;
   } mcr_exp_t;

   logic        clk;          // 25 MHz
   logic        reset;        // Async, active high
   logic        host_wr, host_rd;
   logic [15:0] host_addr, host_wdata;
   logic        alarm_event;  // Alarm source
   logic [15:0] host_rdata;
   logic        host_ack;
   logic [7:0]  gw_active1, gw_active2, gw_active3, gw_active4;
   logic [15:0] port_active;
   logic        net_applied, integ_run, opt_integ_run, demand_run, demand_alarm;
   logic        extremes_clear, active_clear, regen_clear, reactive_clear;
   logic        apparent_clear, preset_load;
   logic [31:0] preset_value;
   mcr_exp_t    notes[$];     // Oldest expectation first
   mcr_exp_t    n;            // Note being checked
   int          errors, checked, cycles, i, seed;
   logic [15:0] gw[4];        // Octets written
   logic [31:0] pre;          // Preset value
   logic [15:0] rst_addr[11] = '{16'h0120, 16'h0121, 16'h0122, 16'h0123, 16'h0124,
      16'h012c, 16'h012d, 16'h0136, 16'h0137, 16'h0160, 16'h0100};
   logic [15:0] rst_val[11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01f6,
      16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   mcr_host_model host (.clk(clk), .host_wr(host_wr), .host_rd(host_rd),
      .host_addr(host_addr), .host_wdata(host_wdata));

   mcr_reg_bank dut (.clk(clk), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
      .host_addr(host_addr), .host_wdata(host_wdata), .alarm_event(alarm_event),
      .host_rdata(host_rdata), .host_ack(host_ack), .gw_active1(gw_active1),
      .gw_active2(gw_active2), .gw_active3(gw_active3), .gw_active4(gw_active4),
      .port_active(port_active), .net_applied(net_applied), .integ_run(integ_run),
      .opt_integ_run(opt_integ_run), .demand_run(demand_run),
      .demand_alarm(demand_alarm), .extremes_clear(extremes_clear),
      .active_clear(active_clear), .regen_clear(regen_clear),
      .reactive_clear(reactive_clear), .apparent_clear(apparent_clear),
      .preset_load(preset_load), .preset_value(preset_value));

   // Command pulses a write should raise: {net,preset,appar,react,regen,act,ext}
   function automatic logic [6:0] exp_pulse(input logic [15:0] a, input logic [15:0] d);
      exp_pulse = 7'h00;
      if (d == mcr_pkg::CMD_GO) begin
         case (a)
            mcr_pkg::A_EXT_CLR:   exp_pulse = 7'h01;
            mcr_pkg::A_E_ALL:     exp_pulse = 7'h1e;
            mcr_pkg::A_E_ACT:     exp_pulse = 7'h02;
            mcr_pkg::A_E_REGEN:   exp_pulse = 7'h04;
            mcr_pkg::A_E_REACT:   exp_pulse = 7'h08;
            mcr_pkg::A_E_APPAR:   exp_pulse = 7'h10;
            mcr_pkg::A_PRE_APPLY: exp_pulse = 7'h20;
            mcr_pkg::A_NET_APPLY: exp_pulse = 7'h40;
            default:              exp_pulse = 7'h00;
         endcase
      end
   endfunction

   // Note a write, then issue it
   task automatic wr_note(input logic [15:0] a, input logic [15:0] d);
      notes.push_back('{1'b0, 16'h0000, exp_pulse(a, d)});
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      wr_note(a, d);
      host.op(1'b1, 1'b0, a, d);
   endtask
   // Note a read with its expected data, then issue it
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      notes.push_back('{1'b1, e, 7'h00});
      host.op(1'b0, 1'b1, a, 16'h0000);
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Each acknowledge retires the oldest note; sampled mid-cycle, clear of the edge
   always @(negedge clk) begin
      if (host_ack === 1'b1) begin
         if (notes.size() == 0) begin
            errors++;
            $display("mismatch at %0t: unexpected acknowledge", $time);
         end else begin
            n = notes.pop_front();
            `chk({net_applied, preset_load, apparent_clear, reactive_clear, regen_clear,
               active_clear, extremes_clear}, n.pulses)
            if (n.rd) `chk(host_rdata, n.data)
         end
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      seed        = 81;
      alarm_event = 1'b0;
      reset       = 1'b1;
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1;
      // Reset values, a write-only place and an unmapped place
      for (i = 0; i < 11; i++) rd(rst_addr[i], rst_val[i]);
      // Octets staged, one out of range, port below range, apply refused
      for (i = 0; i < 4; i++) begin
         gw[i] = (i == 3) ? mcr_pkg::OCTET_MAX : ($random(seed) & 16'h00ff);
         wr(mcr_pkg::A_GW1 + 16'(i), gw[i]);
      end
      wr(mcr_pkg::A_GW2, 16'h0100);
      wr(mcr_pkg::A_PORT, 16'h03ff);
      rd(mcr_pkg::A_PORT, 16'h01f6);
      wr(mcr_pkg::A_PORT, 16'h0400);
      wr(mcr_pkg::A_NET_APPLY, 16'h0002);
      host.idle();
      `chk(port_active, 16'h01f6)
      `chk(gw_active4, 8'h00)
      for (i = 0; i < 4; i++) rd(mcr_pkg::A_GW1 + 16'(i), gw[i]);
      wr(mcr_pkg::A_NET_APPLY, 16'h0001);
      host.idle();
      `chk(port_active, 16'h0400)
      `chk({gw_active1, gw_active2, gw_active3, gw_active4},
         {gw[0][7:0], gw[1][7:0], gw[2][7:0], gw[3][7:0]})
      // Run controls, one value refused
      wr(mcr_pkg::A_INTEG, 16'h0000);
      wr(mcr_pkg::A_OPT_INTEG, 16'h0001);
      wr(mcr_pkg::A_DEM_RUN, 16'h0001);
      wr(mcr_pkg::A_DEM_RUN, 16'h0002);
      host.idle();
      `chk({integ_run, opt_integ_run, demand_run}, 3'b011)
      rd(mcr_pkg::A_DEM_RUN, 16'h0001);
      // Alarm raised, write 1 ignored, write 0 clears
      alarm_event = 1'b1;
      host.idle();
      alarm_event = 1'b0;
      `chk(demand_alarm, 1'b1)
      wr(mcr_pkg::A_DEM_ALM, 16'h0001);
      rd(mcr_pkg::A_DEM_ALM, 16'h0001);
      wr(mcr_pkg::A_DEM_ALM, 16'h0000);
      rd(mcr_pkg::A_DEM_ALM, 16'h0000);
      `chk(demand_alarm, 1'b0)
      // Every clear command, refused then accepted
      for (i = 0; i < 6; i++) begin
         wr(mcr_pkg::A_EXT_CLR + 16'(i), 16'h0002);
         wr(mcr_pkg::A_EXT_CLR + 16'(i), 16'h0001);
      end
      // Preset staged in halves, apply refused, then loaded
      pre = $random(seed);
      wr_note(mcr_pkg::A_PRE_LO, pre[15:0]);
      wr_note(mcr_pkg::A_PRE_HI, pre[31:16]);
      host.stage32(mcr_pkg::A_PRE_LO, pre);
      wr(mcr_pkg::A_PRE_APPLY, 16'h0000);
      wr(mcr_pkg::A_PRE_APPLY, 16'h0001);
      host.idle();
      `chk(preset_value, pre)
      wr(mcr_pkg::A_RGN_PRE_LO, 16'h1234);
      rd(mcr_pkg::A_RGN_PRE_LO, 16'h0000);
      rd(mcr_pkg::A_PRE_LO, 16'h0000);
      repeat (3) host.idle();
      `chk(notes.size(), 0)
      report_and_stop();
   end
endmodule // mcr_reg_bank_bench
